/* rtl/csr_pkg.sv */
package csr_pkg;

  localparam int CSR_ADDR_W = 8;
  localparam int CSR_DATA_W = 8;

  localparam logic [CSR_ADDR_W-1:0] CSR_CUR_ADDR = 8'h04;
  localparam logic [CSR_ADDR_W-1:0] CSR_VTH_ADDR = 8'h05;

  // Charge current register fields
  localparam int CSR_CUR_UNUSED_BIT = 7;
  localparam int CSR_FAST_MSB = 6;
  localparam int CSR_FAST_LSB = 2;
  localparam int CSR_TRK_MSB = 1;
  localparam int CSR_TRK_LSB = 0;

  // Voltage threshold register fields
  localparam int CSR_RDIS_BIT = 7;
  localparam int CSR_RTH_MSB = 6;
  localparam int CSR_RTH_LSB = 5;
  localparam int CSR_DEAD_MSB = 4;
  localparam int CSR_DEAD_LSB = 3;
  localparam int CSR_WEAK_MSB = 2;
  localparam int CSR_WEAK_LSB = 0;

  // Reset values
  localparam logic [4:0] CSR_FAST_RST_DEF = 5'h09;
  localparam logic [1:0] CSR_TRK_RST = 2'h2;
  localparam logic CSR_RDIS_RST = 1'b0;
  localparam logic [1:0] CSR_RTH_RST = 2'h3;
  localparam logic [1:0] CSR_DEAD_RST = 2'h1;
  localparam logic [2:0] CSR_WEAK_RST = 3'h3;

  // Fast codes at and above this all select the top current
  localparam logic [4:0] CSR_FAST_SAT = 5'h17;

  // Decoded levels
  localparam logic [6:0] CSR_TRK_MA_0 = 7'h05;
  localparam logic [6:0] CSR_TRK_MA_1 = 7'h0a;
  localparam logic [6:0] CSR_TRK_MA_2 = 7'h14;
  localparam logic [6:0] CSR_TRK_MA_3 = 7'h50;
  localparam logic [8:0] CSR_RTH_MV_0 = 9'h050;
  localparam logic [8:0] CSR_RTH_MV_UNDEF = 9'h000;
  localparam logic [8:0] CSR_RTH_MV_2 = 9'h0c8;
  localparam logic [8:0] CSR_RTH_MV_3 = 9'h104;
  localparam logic [5:0] CSR_DEAD_DV_0 = 6'h14;
  localparam logic [5:0] CSR_DEAD_DV_1 = 6'h19;
  localparam logic [5:0] CSR_DEAD_DV_2 = 6'h1a;
  localparam logic [5:0] CSR_DEAD_DV_3 = 6'h1d;
  localparam logic [5:0] CSR_WEAK_DV_BASE = 6'h1b;

  typedef struct packed {
    logic [4:0] fast_current_code;
    logic [1:0] trickle_current_code;
    logic recharge_disable;
    logic [1:0] recharge_threshold_code;
    logic [1:0] dead_battery_threshold_code;
    logic [2:0] weak_battery_threshold_code;
  } csr_cfg_t;

  typedef struct packed {
    logic [4:0] fast_code_eff;
    logic [6:0] trickle_ma;
    logic recharge_enable;
    logic [8:0] recharge_mv;
    logic [5:0] dead_dv;
    logic [5:0] weak_dv;
  } csr_levels_t;

endpackage : csr_pkg

/* rtl/csr_setpoint_regs.sv */
module csr_setpoint_regs #(
  parameter logic [4:0] FAST_RST = csr_pkg::CSR_FAST_RST_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [csr_pkg::CSR_ADDR_W-1:0] i_addr,
  input wire logic [csr_pkg::CSR_DATA_W-1:0] i_wdata,
  output logic [csr_pkg::CSR_DATA_W-1:0] o_rdata,
  output logic o_rd_valid,
  output csr_pkg::csr_cfg_t o_cfg,
  output csr_pkg::csr_levels_t o_levels
);
  import csr_pkg::*;

  function automatic logic [6:0] trk_ma(input logic [1:0] code);
    logic [6:0] v;
    v = CSR_TRK_MA_0;
    unique case (code)
      2'h0: v = CSR_TRK_MA_0;
      2'h1: v = CSR_TRK_MA_1;
      2'h2: v = CSR_TRK_MA_2;
      2'h3: v = CSR_TRK_MA_3;
    endcase
    return v;
  endfunction : trk_ma

  function automatic logic [8:0] rth_mv(input logic [1:0] code);
    logic [8:0] v;
    v = CSR_RTH_MV_UNDEF;
    unique case (code)
      2'h0: v = CSR_RTH_MV_0;
      2'h1: v = CSR_RTH_MV_UNDEF;
      2'h2: v = CSR_RTH_MV_2;
      2'h3: v = CSR_RTH_MV_3;
    endcase
    return v;
  endfunction : rth_mv

  function automatic logic [5:0] dead_dv(input logic [1:0] code);
    logic [5:0] v;
    v = CSR_DEAD_DV_0;
    unique case (code)
      2'h0: v = CSR_DEAD_DV_0;
      2'h1: v = CSR_DEAD_DV_1;
      2'h2: v = CSR_DEAD_DV_2;
      2'h3: v = CSR_DEAD_DV_3;
    endcase
    return v;
  endfunction : dead_dv

  csr_cfg_t cfg_reg;
  csr_cfg_t cfg_next;
  logic [CSR_DATA_W-1:0] rdata_reg;
  logic [CSR_DATA_W-1:0] rdata_next;
  logic rd_valid_reg;

  wire logic sel_cur = (i_addr == CSR_CUR_ADDR);
  wire logic sel_vth = (i_addr == CSR_VTH_ADDR);
  wire logic wr_cur = i_wr_en && sel_cur;
  wire logic wr_vth = i_wr_en && sel_vth;

  // Unused bit 7 is simply never stored
  wire logic [CSR_DATA_W-1:0] cur_view = {1'b0, cfg_reg.fast_current_code,
                                          cfg_reg.trickle_current_code};
  wire logic [CSR_DATA_W-1:0] vth_view = {cfg_reg.recharge_disable,
                                          cfg_reg.recharge_threshold_code,
                                          cfg_reg.dead_battery_threshold_code,
                                          cfg_reg.weak_battery_threshold_code};

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cur) begin
      cfg_next.fast_current_code = i_wdata[CSR_FAST_MSB:CSR_FAST_LSB];
      cfg_next.trickle_current_code = i_wdata[CSR_TRK_MSB:CSR_TRK_LSB];
    end
    if (wr_vth) begin
      cfg_next.recharge_disable = i_wdata[CSR_RDIS_BIT];
      cfg_next.recharge_threshold_code = i_wdata[CSR_RTH_MSB:CSR_RTH_LSB];
      cfg_next.dead_battery_threshold_code = i_wdata[CSR_DEAD_MSB:CSR_DEAD_LSB];
      cfg_next.weak_battery_threshold_code = i_wdata[CSR_WEAK_MSB:CSR_WEAK_LSB];
    end
  end

  // Unmapped reads return zero rather than stale data
  assign rdata_next = !i_rd_en ? rdata_reg :
                      sel_cur ? cur_view :
                      sel_vth ? vth_view : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_reg.fast_current_code <= FAST_RST;
      cfg_reg.trickle_current_code <= CSR_TRK_RST;
      cfg_reg.recharge_disable <= CSR_RDIS_RST;
      cfg_reg.recharge_threshold_code <= CSR_RTH_RST;
      cfg_reg.dead_battery_threshold_code <= CSR_DEAD_RST;
      cfg_reg.weak_battery_threshold_code <= CSR_WEAK_RST;
      rdata_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= i_rd_en;
    end
  end

  assign o_cfg = cfg_reg;
  assign o_rdata = rdata_reg;
  assign o_rd_valid = rd_valid_reg;

  // Stored code is kept as written so it reads back; the charge loop sees it clamped
  wire logic fast_sat = (cfg_reg.fast_current_code >= CSR_FAST_SAT);
  assign o_levels.fast_code_eff = fast_sat ? CSR_FAST_SAT : cfg_reg.fast_current_code;
  assign o_levels.trickle_ma = trk_ma(cfg_reg.trickle_current_code);
  assign o_levels.recharge_enable = !cfg_reg.recharge_disable;
  assign o_levels.recharge_mv = rth_mv(cfg_reg.recharge_threshold_code);
  assign o_levels.dead_dv = dead_dv(cfg_reg.dead_battery_threshold_code);
  assign o_levels.weak_dv = CSR_WEAK_DV_BASE
                            + {3'h0, cfg_reg.weak_battery_threshold_code};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  cur_addr_read_a: assert property (i_rd_en && sel_cur |=> o_rd_valid
    && o_rdata[CSR_FAST_MSB:CSR_TRK_LSB] == {$past(cfg_reg.fast_current_code),
                                            $past(cfg_reg.trickle_current_code)})
    else $error("charge current readback mismatch");

  fast_write_a: assert property (wr_cur |=>
    o_cfg.fast_current_code == $past(i_wdata[CSR_FAST_MSB:CSR_FAST_LSB]))
    else $error("fast code not stored");

  fast_clamp_a: assert property (o_cfg.fast_current_code >= 5'h17 |->
    o_levels.fast_code_eff == 5'h17)
    else $error("fast code not clamped");

  trickle_level_a: assert property (wr_cur && i_wdata[1:0] == 2'h3 |=>
    o_levels.trickle_ma == 7'h50 && o_cfg.trickle_current_code == 2'h3)
    else $error("trickle level wrong");

  vth_addr_read_a: assert property (i_rd_en && sel_vth && !i_wr_en ##1 !i_wr_en |->
    o_rdata == vth_view)
    else $error("threshold readback mismatch");

  rch_disable_a: assert property (wr_vth |=>
    o_levels.recharge_enable == !$past(i_wdata[CSR_RDIS_BIT]))
    else $error("recharge disable not applied");

  rth_hold_a: assert property (!wr_vth |=> $stable(o_cfg.recharge_threshold_code)
    && $stable(o_cfg.dead_battery_threshold_code))
    else $error("threshold changed without write");

  dead_level_a: assert property (o_cfg.dead_battery_threshold_code == 2'h1 |->
    o_levels.dead_dv == 6'h19)
    else $error("dead level wrong");

  weak_level_a: assert property (wr_vth ##1 !wr_vth |->
    o_levels.weak_dv == 6'h1b + {3'h0, $past(i_wdata[2:0])})
    else $error("weak level wrong");

  unused_bit_a: assert property (i_rd_en && sel_cur |=> !o_rdata[7])
    else $error("unused bit reads one");

  unmapped_a: assert property (i_rd_en && !sel_cur && !sel_vth |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  rd_valid_rise_a: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe gave no valid");

  rd_valid_fall_a: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("valid without read strobe");

  cur_hold_a: assert property (!wr_cur |=> $stable(o_cfg.fast_current_code)
    && $stable(o_cfg.trickle_current_code))
    else $error("current codes changed without write");

  fast_reset_a: assert property ($fell(i_rst) |->
    o_cfg.fast_current_code == FAST_RST)
    else $error("fast code reset value wrong");

  trk_reset_a: assert property ($fell(i_rst) |->
    o_cfg.trickle_current_code == CSR_TRK_RST && o_levels.trickle_ma == 7'h14)
    else $error("trickle reset value wrong");

  rdis_reset_a: assert property ($fell(i_rst) |->
    o_cfg.recharge_disable == CSR_RDIS_RST && o_levels.recharge_enable)
    else $error("recharge disable reset value wrong");

  rth_reset_a: assert property ($fell(i_rst) |->
    o_cfg.recharge_threshold_code == CSR_RTH_RST && o_levels.recharge_mv == 9'h104)
    else $error("recharge threshold reset value wrong");

  dead_reset_a: assert property ($fell(i_rst) |->
    o_cfg.dead_battery_threshold_code == CSR_DEAD_RST && o_levels.dead_dv == 6'h19)
    else $error("dead threshold reset value wrong");

  weak_reset_a: assert property ($fell(i_rst) |->
    o_cfg.weak_battery_threshold_code == CSR_WEAK_RST && o_levels.weak_dv == 6'h1e)
    else $error("weak threshold reset value wrong");

  rth_undef_a: assert property (o_cfg.recharge_threshold_code == 2'h1 |->
    o_levels.recharge_mv == 9'h000)
    else $error("undefined recharge code not zero");

  weak_range_a: assert property (o_levels.weak_dv >= 6'h1b
    && o_levels.weak_dv <= 6'h22)
    else $error("weak level out of range");

  cur_write_c: cover property (wr_cur ##1 i_rd_en && sel_cur);
  vth_write_c: cover property (wr_vth ##1 i_rd_en && sel_vth);
  sat_code_c: cover property (fast_sat);
  unmapped_c: cover property (i_rd_en && !sel_cur && !sel_vth);
  rd_wr_same_c: cover property (wr_cur && i_rd_en && sel_cur);

endmodule : csr_setpoint_regs

/* testbench/charge_setpoint_registers_tb_top.sv */
module charge_setpoint_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csr_pkg::*;
  localparam logic [4:0] FAST = 5'h09;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wr, rd, rd_valid;
  logic [7:0] addr, wdata, rdata, cur_m, vth_m, a;
  csr_cfg_t cfg;
  csr_levels_t lv;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  always #25 i_clk = ~i_clk;
  csr_host_model host_u (.i_clk(i_clk), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr),
    .o_wdata(wdata));
  csr_setpoint_regs #(.FAST_RST(FAST)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_cfg(cfg), .o_levels(lv));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic csr_levels_t lvl(input logic [7:0] c, input logic [7:0] v);
    logic [6:0] trk[4] = '{7'h05, 7'h0a, 7'h14, 7'h50};
    logic [8:0] mv[4] = '{9'h050, 9'h000, 9'h0c8, 9'h104};
    logic [5:0] dv[4] = '{6'h14, 6'h19, 6'h1a, 6'h1d};
    lvl = '{(c[6:2] > 5'h17) ? 5'h17 : c[6:2], trk[c[1:0]], ~v[7], mv[v[6:5]], dv[v[4:3]],
      6'h1b + 6'(v[2:0])};
  endfunction : lvl
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic also_rd);
    host_u.put(1'b1, also_rd, a, d);
    if (a == 8'h04) cur_m = d & 8'h7f;
    if (a == 8'h05) vth_m = d;
    chk(34'(cfg), 34'({cur_m[6:0], vth_m}));
    chk(lv, lvl(cur_m, vth_m));
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    exp_q.push_back(a == 8'h04 ? cur_m : (a == 8'h05 ? vth_m : 8'h00));
    host_u.put(1'b0, 1'b1, a, 8'h00);
  endtask : rd_reg
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  always @(posedge i_clk) begin
    #1;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(34'h1, 34'h0);
      else chk(34'(rdata), 34'(exp_q.pop_front()));
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h5ee2));
    repeat (20) @(posedge i_clk);
    #5 i_rst = 1'b0;
    cur_m = {1'b0, FAST, 2'h2};
    vth_m = 8'h6b;
    chk(lv, lvl(cur_m, vth_m));
    chk(34'({rd_valid, rdata}), 34'h0);
    rd_reg(8'h04);
    rd_reg(8'h05);
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h04, {i[0], 5'h13 + 5'(i), i[1:0]}, 1'b0);
      wr_reg(8'h05, {i[0], i[1:0], i[2:1], i[2:0]}, 1'b0);
      rd_reg(8'h04);
      rd_reg(8'h05);
    end
    // Read and write together must return the old contents
    exp_q.push_back(cur_m);
    wr_reg(8'h04, 8'h55, 1'b1);
    repeat (16) begin
      a = 8'h03 + 8'($urandom % 4);
      wr_reg(a, 8'($urandom), 1'b0);
      rd_reg(a);
    end
    @(posedge i_clk);
    #5 i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #5 i_rst = 1'b0;
    cur_m = {1'b0, FAST, 2'h2};
    vth_m = 8'h6b;
    chk(lv, lvl(cur_m, vth_m));
    chk(34'({rd_valid, rdata}), 34'h0);
    rd_reg(8'h04);
    repeat (3) @(posedge i_clk);
    chk(34'(exp_q.size()), 34'h0);
    final_report();
  end
endmodule : charge_setpoint_registers_tb_top

/* testbench/csr_host_model.sv */
module csr_host_model (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // Idle address and data lines show the inverse, so stale values cannot pass for fresh ones
  task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #5;
    o_wr_en = w;
    o_rd_en = r;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #5;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : put
endmodule : csr_host_model
